// file: hw/fsc_host.sv
`timescale 1ns/1ns
module fsc_host import fsc_pkg::*; #(
  parameter int RP_CYC    = T_RP_CYC,
  parameter int RH_CYC    = T_RH_CYC,
  parameter int RDY_ALG   = T_READY_ALG_CYC,
  parameter int RDY_IDLE  = T_READY_IDL_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              req,
  input  wire fsc_op_t           op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              byte_mode,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  output logic                   restart_needed,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_reset_n,
  output logic                   flash_byte_n,
  output logic                   flash_id_vpp_en,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  input  wire logic              ready_busy_n
);

  // ----------------------------------------
  // per-step cycle for each operation
  // ----------------------------------------
  function automatic fsc_step_t step_of(fsc_op_t o, logic [2:0] s,
                                        logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    fsc_step_t r;
    logic [ADDR_W-1:0] id_a;
    r    = '0;
    // sector bits and selector bits kept, everything else cleared, a6 low
    id_a = '0;
    id_a[SECT_LSB +: SECT_W] = a[SECT_LSB +: SECT_W];
    id_a[SEL_W-1:0]          = a[SEL_W-1:0];
    id_a[A6_BIT]             = 1'b0;
    unique case (o)
      FSC_OP_WRITE: begin
        r.wr   = 1'b1;
        r.last = 1'b1;
        r.addr = a;
        r.data = d;
      end
      FSC_OP_ID_HV: begin
        r.last    = 1'b1;
        r.capture = 1'b1;
        r.addr    = id_a;
      end
      FSC_OP_ID_CMD: begin
        // unlock, unlock, autoselect, read code, reset command
        r.wr = 1'b1;
        unique case (s)
          3'h0: begin r.addr = UNLOCK1_ADDR; r.data = UNLOCK1_DATA; end
          3'h1: begin r.addr = UNLOCK2_ADDR; r.data = UNLOCK2_DATA; end
          3'h2: begin r.addr = UNLOCK1_ADDR; r.data = AUTOSEL_CMD;  end
          3'h3: begin r.wr = 1'b0; r.capture = 1'b1; r.addr = id_a; end
          default: begin r.last = 1'b1; r.data = RESET_CMD; end
        endcase
      end
      default: begin
        r.last    = 1'b1;
        r.capture = 1'b1;
        r.addr    = a;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_ISSUE   = 3'b001,
    S_WAIT    = 3'b010,
    S_RST_LOW = 3'b011,
    S_RST_REC = 3'b100,
    S_DONE    = 3'b101
  } fsc_st_t;

  fsc_st_t           st_q, st_d;
  fsc_op_t           op_q, op_d;
  logic [2:0]        step_q, step_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic [DATA_W-1:0] d_q, d_d, rd_q, rd_d;
  logic              alg_q, alg_d, rst_q, rst_d, rs_q, rs_d, byte_q, byte_d;
  fsc_step_t         cur;

  fsc_cyc_if cyc_if ();

  assign cur           = step_of(op_q, step_q, a_q, d_q);
  assign cyc_if.req    = (st_q == S_ISSUE);
  assign cyc_if.wr     = cur.wr;
  assign cyc_if.addr   = cur.addr;
  assign cyc_if.wdata  = cur.data;

  always_comb begin
    st_d   = st_q;
    op_d   = op_q;
    step_d = step_q;
    cnt_d  = cnt_q;
    a_d    = a_q;
    d_d    = d_q;
    rd_d   = rd_q;
    alg_d  = alg_q;
    rst_d  = rst_q;
    rs_d   = rs_q;
    byte_d = byte_q;
    // a new write clears the restart flag; a fresh interrupt sets it again
    if (req && st_q == S_IDLE && op == FSC_OP_WRITE) rs_d = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        byte_d = byte_mode;
        if (req) begin
          op_d   = op;
          a_d    = req_addr;
          d_d    = req_wdata;
          step_d = '0;
          cnt_d  = '0;
          st_d   = (op == FSC_OP_RESET) ? S_RST_LOW : S_ISSUE;
        end
      end
      S_ISSUE: st_d = S_WAIT;
      S_WAIT: begin
        if (cyc_if.ack) begin
          if (cur.capture) begin
            // byte mode: upper lanes are not driven by the device
            rd_d = byte_q ? (cyc_if.rdata & BYTE_MASK) : cyc_if.rdata;
          end
          step_d = step_q + 1'b1;
          st_d   = cur.last ? S_DONE : S_ISSUE;
        end
      end
      S_RST_LOW: begin
        rst_d = 1'b1;
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == '0) begin
          alg_d = !ready_busy_n;
          if (!ready_busy_n) rs_d = 1'b1;
        end
        // first cycle only launches reset_n low, so count RP_CYC full cycles
        if (cnt_q == CNT_W'(RP_CYC)) begin
          rst_d = 1'b0;
          cnt_d = '0;
          st_d  = S_RST_REC;
        end
      end
      S_RST_REC: begin
        cnt_d = cnt_q + 1'b1;
        // ready pin is trusted, recovery time is the upper bound
        if ((cnt_q >= CNT_W'(RH_CYC - 1) && ready_busy_n) ||
            cnt_q == CNT_W'((alg_q ? RDY_ALG : RDY_IDLE) - 1)) begin
          st_d = S_DONE;
        end
      end
      S_DONE: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= S_IDLE;
      op_q   <= FSC_OP_READ;
      step_q <= '0;
      cnt_q  <= '0;
      a_q    <= '0;
      d_q    <= '0;
      rd_q   <= '0;
      alg_q  <= 1'b0;
      rst_q  <= 1'b0;
      rs_q   <= 1'b0;
      byte_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      op_q   <= op_d;
      step_q <= step_d;
      cnt_q  <= cnt_d;
      a_q    <= a_d;
      d_q    <= d_d;
      rd_q   <= rd_d;
      alg_q  <= alg_d;
      rst_q  <= rst_d;
      rs_q   <= rs_d;
      byte_q <= byte_d;
    end
  end

  // id voltage only while a high-voltage read is in flight
  logic vpp_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) vpp_q <= 1'b0;
    else         vpp_q <= (op_d == FSC_OP_ID_HV) && (st_d == S_ISSUE || st_d == S_WAIT);
  end

  fsc_bus_cycle u_cyc (
    .clk    (clk),
    .resetn (resetn),
    .cyc    (cyc_if.slave),
    .ce_n   (flash_ce_n),
    .oe_n   (flash_oe_n),
    .we_n   (flash_we_n),
    .addr   (flash_addr),
    .dq_o   (flash_dq_o),
    .dq_oe  (flash_dq_oe),
    .dq_i   (flash_dq_i)
  );

  assign busy            = (st_q != S_IDLE);
  assign done            = (st_q == S_DONE);
  assign rdata           = rd_q;
  assign restart_needed  = rs_q;
  assign flash_reset_n   = !rst_q;
  assign flash_byte_n    = !byte_q;
  assign flash_id_vpp_en = vpp_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [CNT_W-1:0] low_cnt_q;
  logic [DATA_W-1:0] last_wd_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_q <= '0;
      last_wd_q <= '0;
    end else begin
      low_cnt_q <= flash_reset_n ? '0 : low_cnt_q + 1'b1;
      if (!flash_we_n) last_wd_q <= flash_dq_o;
    end
  end

  sequence s_reset_release;
    !flash_reset_n ##1 flash_reset_n;
  endsequence

  // counter already holds the full low length at the release edge
  a_reset_width: assert property (@(posedge clk) disable iff (!resetn)
    s_reset_release |-> low_cnt_q == CNT_W'(RP_CYC))
    else $error("reset pulse width wrong");
  a_reset_no_access: assert property (@(posedge clk) disable iff (!resetn)
    !flash_reset_n |-> flash_ce_n && flash_oe_n && flash_we_n)
    else $error("bus access during reset");
  a_hv_read_only: assert property (@(posedge clk) disable iff (!resetn)
    flash_id_vpp_en |-> flash_we_n)
    else $error("write while id voltage applied");
  a_hv_a6_low: assert property (@(posedge clk) disable iff (!resetn)
    flash_id_vpp_en && !flash_oe_n |-> !flash_addr[A6_BIT] &&
      flash_addr[SEL_W-1:0] == a_q[SEL_W-1:0])
    else $error("id selector address wrong");
  a_hv_sector: assert property (@(posedge clk) disable iff (!resetn)
    flash_id_vpp_en && !flash_oe_n |-> flash_addr[SECT_LSB +: SECT_W] == a_q[SECT_LSB +: SECT_W])
    else $error("sector address missing in id read");
  a_cmd_id_exit: assert property (@(posedge clk) disable iff (!resetn)
    done && op_q == FSC_OP_ID_CMD |-> last_wd_q == RESET_CMD)
    else $error("autoselect not left by reset command");
  a_restart_flag: assert property (@(posedge clk) disable iff (!resetn)
    st_q == S_RST_LOW && cnt_q == '0 && !ready_busy_n |=> restart_needed)
    else $error("interrupted operation not flagged");
  a_recovery_bound: assert property (@(posedge clk) disable iff (!resetn)
    st_q == S_RST_REC && !alg_q |-> cnt_q < CNT_W'(RDY_IDLE))
    else $error("idle reset recovery overran");
  // only capturing ops refresh rdata; a reset keeps an older word-mode value
  a_byte_mask: assert property (@(posedge clk) disable iff (!resetn)
    byte_q && done && op_q inside {FSC_OP_READ, FSC_OP_ID_HV, FSC_OP_ID_CMD} |-> rdata[DATA_W-1:8] == '0)
    else $error("upper byte not cleared in byte mode");

endmodule

// file: hw/fsc_pkg.sv
package fsc_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W   = 18;
  localparam int DATA_W   = 16;
  localparam int SECT_LSB = 12;
  localparam int SECT_W   = 6;
  localparam int SEL_W    = 2;
  localparam int A6_BIT   = 6;

  // ----------------------------------------
  // timing, ns and derived cycles
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int T_ACC_NS        = 70;
  localparam int T_WP_NS         = 35;
  localparam int T_RP_NS         = 500;
  localparam int T_RH_NS         = 50;
  localparam int T_READY_ALG_NS  = 20000;
  localparam int T_READY_IDLE_NS = 500;
  localparam int T_ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WP_CYC        = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RP_CYC        = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RH_CYC        = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_READY_ALG_CYC = (T_READY_ALG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_READY_IDL_CYC = (T_READY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 16;

  // ----------------------------------------
  // command words, word-mode addresses
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 18'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 18'h002aa;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [DATA_W-1:0] AUTOSEL_CMD  = 16'h0090;
  localparam logic [DATA_W-1:0] RESET_CMD    = 16'h00f0;
  localparam logic [DATA_W-1:0] BYTE_MASK    = 16'h00ff;

  // id selector codes on the low address bits
  localparam logic [SEL_W-1:0] SEL_MFR  = 2'h0;
  localparam logic [SEL_W-1:0] SEL_DEV  = 2'h1;
  localparam logic [SEL_W-1:0] SEL_PROT = 2'h2;
  localparam logic [SEL_W-1:0] SEL_CONT = 2'h3;

  localparam logic [2:0] STEP_W_LAST = 3'h4;
  localparam logic [2:0] STEP_READ   = 3'h3;

  typedef enum logic [2:0] {
    FSC_OP_READ    = 3'b000,
    FSC_OP_WRITE   = 3'b001,
    FSC_OP_ID_HV   = 3'b010,
    FSC_OP_ID_CMD  = 3'b011,
    FSC_OP_RESET   = 3'b100
  } fsc_op_t;

  typedef struct packed {
    logic              wr;
    logic              last;
    logic              capture;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsc_step_t;

endpackage

// file: hw/fsc_cyc_if.sv
`timescale 1ns/1ns
interface fsc_cyc_if;
  import fsc_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              ack;
  logic [DATA_W-1:0] rdata;
  modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport slave  (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// file: hw/fsc_bus_cycle.sv
`timescale 1ns/1ns
module fsc_bus_cycle import fsc_pkg::*; #(
  parameter int ACC_CYC = T_ACC_CYC,
  parameter int WP_CYC  = T_WP_CYC
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  fsc_cyc_if.slave               cyc,
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   we_n,
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe,
  input  wire logic [DATA_W-1:0] dq_i
);

  // ----------------------------------------
  // one asynchronous bus cycle per request
  // ----------------------------------------
  typedef enum logic [1:0] {
    E_IDLE   = 2'b00,
    E_SETUP  = 2'b01,
    E_STROBE = 2'b10,
    E_HOLD   = 2'b11
  } fsc_cyc_st_t;

  fsc_cyc_st_t       st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    wr_d   = wr_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    unique case (st_q)
      E_IDLE: begin
        if (cyc.req) begin
          wr_d   = cyc.wr;
          addr_d = cyc.addr;
          wd_d   = cyc.wdata;
          st_d   = E_SETUP;
        end
      end
      E_SETUP: begin
        cnt_d = '0;
        st_d  = E_STROBE;
      end
      E_STROBE: begin
        cnt_d = cnt_q + 1'b1;
        // sample on the last strobe cycle, access time has elapsed
        if (cnt_q == CNT_W'(wr_q ? WP_CYC - 1 : ACC_CYC - 1)) begin
          if (!wr_q) rd_d = dq_i;
          st_d = E_HOLD;
        end
      end
      E_HOLD: st_d = E_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= E_IDLE;
      cnt_q  <= '0;
      wr_q   <= 1'b0;
      addr_q <= '0;
      wd_q   <= '0;
      rd_q   <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      wr_q   <= wr_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
    end
  end

  // pin registers: strobes only low in the strobe phase
  logic ce_q, oe_q, we_q, dqoe_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ce_q   <= 1'b1;
      oe_q   <= 1'b1;
      we_q   <= 1'b1;
      dqoe_q <= 1'b0;
    end else begin
      ce_q   <= !(st_d == E_STROBE);
      oe_q   <= !(st_d == E_STROBE && !wr_d);
      we_q   <= !(st_d == E_STROBE && wr_d);
      // data held one cycle past we rise for hold time
      dqoe_q <= wr_d && (st_d == E_STROBE || st_d == E_HOLD);
    end
  end

  assign ce_n      = ce_q;
  assign oe_n      = oe_q;
  assign we_n      = we_q;
  assign addr      = addr_q;
  assign dq_o      = wd_q;
  assign dq_oe     = dqoe_q;
  assign cyc.ack   = (st_q == E_HOLD);
  assign cyc.rdata = rd_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_wr_strobe;
    !we_n [*4];
  endsequence

  a_no_contention: assert property (@(posedge clk) disable iff (!resetn)
    dq_oe |-> oe_n)
    else $error("host drives data while flash outputs enabled");
  a_write_pulse_min: assert property (@(posedge clk) disable iff (!resetn)
    $fell(we_n) |-> s_wr_strobe ##1 we_n)
    else $error("write strobe width wrong");
  a_read_ack_time: assert property (@(posedge clk) disable iff (!resetn)
    $fell(oe_n) |-> !oe_n [*7] ##1 (oe_n && cyc.ack))
    else $error("read cycle length wrong");

endmodule

// file: bench/fsc_flash_model.sv
`timescale 1ns/1ns
module fsc_flash_model import fsc_pkg::*; #(
  parameter logic [7:0]  MFR_ID  = 8'h5e,  // arbitrary value
  parameter logic [7:0]  DEV_HI  = 8'h5b,  // arbitrary value
  parameter logic [7:0]  DEV_TOP = 8'h61,  // arbitrary value
  parameter logic [7:0]  DEV_BOT = 8'h62,  // arbitrary value
  parameter logic [7:0]  CONT_ID = 8'h6c,  // arbitrary value
  parameter logic [10:0] PROT    = 11'h483,
  parameter int          ACC     = 4,
  parameter int          ALG_REC = 12
) (
  input  wire logic              clk,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              reset_n,
  input  wire logic              byte_n,
  input  wire logic              vpp,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              top_boot,
  input  wire logic              start_alg,
  output logic [DATA_W-1:0]      dq,
  output logic                   ready_busy_n
);
  // ----------------------------------------
  // behavioural device
  // ----------------------------------------
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] dout_q = '0;
  logic [ADDR_W-1:0] addr_q = '0;
  logic [1:0]        step_q = 2'h0;
  logic              asel_q = 1'b0;
  logic              we_q   = 1'b1;
  logic              ce_q   = 1'b1;
  logic              drive;
  int                stable_q, busy_q;

  function automatic logic [3:0] sect(input logic [5:0] s, input logic top);
    if (top) begin
      if (s[5:3] != 3'h7) return {1'b0, s[5:3]};
      if (!s[2]) return 4'h7;
      if (s[1]) return 4'ha;
      return 4'h8 + {3'h0, s[0]};
    end
    if (s[5:3] != 3'h0) return {1'b0, s[5:3]} + 4'h3;
    if (s[2]) return 4'h3;
    if (s[1]) return 4'h1 + {3'h0, s[0]};
    return 4'h0;
  endfunction

  always_comb begin
    val = addr[15:0] ^ 16'h3c96;
    if ((vpp || asel_q) && !addr[A6_BIT]) begin
      case (addr[1:0])
        SEL_MFR:  val = {8'h00, MFR_ID};
        SEL_DEV:  val = {DEV_HI, top_boot ? DEV_TOP : DEV_BOT};
        SEL_PROT: val = {15'h0, PROT[sect(addr[17:12], top_boot)]};
        default:  val = {8'h00, CONT_ID};
      endcase
    end
    // upper byte is not driven in byte mode, so show junk there
    if (!byte_n) val[15:8] = ~dout_q[15:8];
  end

  assign drive        = reset_n && !ce_n && !oe_n;
  // invalid data before access time; released bus shows inverted last value
  assign dq           = drive ? (stable_q >= ACC ? val : ~val) : ~dout_q;
  assign ready_busy_n = (busy_q == 0);

  always @(posedge clk) begin
    addr_q   <= addr;
    we_q     <= we_n;
    ce_q     <= ce_n;
    stable_q <= (addr == addr_q) ? stable_q + 1 : 0;
    if (drive && stable_q >= ACC) begin
      dout_q <= val;
    end
    if (!reset_n) begin
      asel_q <= 1'b0;
      step_q <= 2'h0;
    // host lifts chip-select with the write strobe, so use the select of the cycle before
    end else if (we_n && !we_q && !ce_q) begin
      if (din[7:0] == RESET_CMD[7:0]) begin
        asel_q <= 1'b0;
        step_q <= 2'h0;
      end else if (step_q == 2'h0 && addr == UNLOCK1_ADDR && din == UNLOCK1_DATA) begin
        step_q <= 2'h1;
      end else if (step_q == 2'h1 && addr == UNLOCK2_ADDR && din == UNLOCK2_DATA) begin
        step_q <= 2'h2;
      end else if (step_q == 2'h2 && addr == UNLOCK1_ADDR && din == AUTOSEL_CMD) begin
        asel_q <= 1'b1;
        step_q <= 2'h0;
      end else begin
        step_q <= 2'h0;
      end
    end
    if (start_alg) begin
      busy_q <= 200;
    end else if (!reset_n && busy_q > ALG_REC) begin
      busy_q <= ALG_REC;
    end else if (busy_q != 0) begin
      busy_q <= busy_q - 1;
    end
  end
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench import fsc_pkg::*;;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  localparam logic [10:0] PROT = 11'h483;
  localparam logic [15:0] PAT  = 16'h3c96;
  localparam logic [7:0]  MFR  = 8'h5e;
  localparam logic [7:0]  DHI  = 8'h5b;
  localparam logic [7:0]  DTOP = 8'h61;
  localparam logic [7:0]  CONT = 8'h6c;
  logic clk, resetn, req, byte_mode, top_boot, start_alg;
  logic busy, done, restart_needed, f_ce_n, f_oe_n, f_we_n, f_reset_n, f_byte_n, f_vpp, f_dq_oe, f_rb_n;
  fsc_op_t op;
  logic [ADDR_W-1:0] req_addr, f_addr;
  logic [DATA_W-1:0] req_wdata, rdata, f_dq_o, f_dq_i, m_dq;
  int n_errors, checked, cycles, rst_low;

  assign f_dq_i = f_dq_oe ? f_dq_o : m_dq;

  fsc_host #(.RP_CYC(4), .RH_CYC(5), .RDY_ALG(20), .RDY_IDLE(8)) dut (
    .clk(clk), .resetn(resetn), .req(req), .op(op), .req_addr(req_addr), .req_wdata(req_wdata),
    .byte_mode(byte_mode), .busy(busy), .done(done), .rdata(rdata), .restart_needed(restart_needed),
    .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n), .flash_we_n(f_we_n), .flash_reset_n(f_reset_n),
    .flash_byte_n(f_byte_n), .flash_id_vpp_en(f_vpp), .flash_addr(f_addr), .flash_dq_o(f_dq_o),
    .flash_dq_oe(f_dq_oe), .flash_dq_i(f_dq_i), .ready_busy_n(f_rb_n)
  );

  fsc_flash_model #(.MFR_ID(MFR), .DEV_HI(DHI), .DEV_TOP(DTOP), .CONT_ID(CONT), .PROT(PROT)) fm (
    .clk(clk), .ce_n(f_ce_n), .oe_n(f_oe_n), .we_n(f_we_n), .reset_n(f_reset_n), .byte_n(f_byte_n),
    .vpp(f_vpp), .addr(f_addr), .din(f_dq_o), .top_boot(top_boot), .start_alg(start_alg), .dq(m_dq),
    .ready_busy_n(f_rb_n)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      $display("BAD run length expected finish seen hang");
      conclude();
    end
  end

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // done sampled on the falling edge, clear of the launching edge
  task automatic do_op(input fsc_op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
    int n;
    @(posedge clk);
    req       <= 1'b1;
    op        <= o;
    req_addr  <= a;
    req_wdata <= w;
    @(posedge clk);
    req     <= 1'b0;
    n       = 0;
    rst_low = 0;
    do begin
      @(negedge clk);
      n++;
      if (f_reset_n === 1'b0) rst_low++;
    end while (done !== 1'b1 && n < 400);
    if (done !== 1'b1) check("done pulse", 16'h0001, 16'h0000);
    check("busy at done", 16'h0001, {15'h0, busy});
  endtask

  function automatic logic [7:0] id_exp(input logic [1:0] sel, input logic p);
    case (sel)
      SEL_MFR:  return MFR;
      SEL_DEV:  return DTOP;
      SEL_PROT: return {7'h00, p};
      default:  return CONT;
    endcase
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_read;
    logic [ADDR_W-1:0] a[4] = '{18'h00000, 18'h3ffff, 18'h12345, 18'h2aaaa};
    foreach (a[i]) begin
      do_op(FSC_OP_READ, a[i], 16'h0000);
      check("read data", a[i][15:0] ^ PAT, rdata);
    end
    $display("t_read finished");
  endtask

  task automatic t_byte;
    @(posedge clk) byte_mode <= 1'b1;
    do_op(FSC_OP_READ, 18'h01234, 16'h0000);
    check("byte pin", 16'h0000, {15'h0, f_byte_n});
    check("byte read", {8'h00, 8'h34 ^ PAT[7:0]}, rdata);
    @(posedge clk) byte_mode <= 1'b0;
    $display("t_byte finished");
  endtask

  task automatic t_hv_id;
    for (int s = 0; s < 4; s++) begin
      do_op(FSC_OP_ID_HV, {16'h0000, s[1:0]}, 16'h0000);
      check("hv id code", {8'h00, id_exp(s[1:0], PROT[0])}, {8'h00, rdata[7:0]});
      if (s == 1) check("device id word", {DHI, DTOP}, rdata);
    end
    $display("t_hv_id finished");
  endtask

  task automatic t_prot;
    logic [5:0] ts[9] = '{6'h00, 6'h08, 6'h30, 6'h38, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f};
    int         ti[9] = '{0, 1, 6, 7, 7, 8, 9, 10, 10};
    logic [5:0] bs[8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h08, 6'h38};
    int         bi[8] = '{0, 0, 1, 2, 3, 3, 4, 10};
    logic [5:0] s;
    int         idx;
    for (int i = 0; i < 17; i++) begin
      s   = (i < 9) ? ts[i] : bs[i-9];
      idx = (i < 9) ? ti[i] : bi[i-9];
      @(posedge clk) top_boot <= (i < 9);
      do_op(FSC_OP_ID_HV, {s, 10'h000, SEL_PROT}, 16'h0000);
      check("prot status", {15'h0, PROT[idx]}, {8'h00, rdata[7:0]});
    end
    @(posedge clk) top_boot <= 1'b1;
    $display("t_prot finished");
  endtask

  task automatic t_cmd_id;
    for (int s = 0; s < 4; s++) begin
      do_op(FSC_OP_ID_CMD, {6'h3e, 10'h000, s[1:0]}, 16'h0000);
      check("cmd id code", {8'h00, id_exp(s[1:0], PROT[10])}, {8'h00, rdata[7:0]});
    end
    do_op(FSC_OP_READ, 18'h00555, 16'h0000);
    check("read after id", 16'h0555 ^ PAT, rdata);
    $display("t_cmd_id finished");
  endtask

  task automatic t_reset_idle;
    do_op(FSC_OP_WRITE, UNLOCK1_ADDR, UNLOCK1_DATA);
    do_op(FSC_OP_WRITE, UNLOCK2_ADDR, UNLOCK2_DATA);
    do_op(FSC_OP_WRITE, UNLOCK1_ADDR, AUTOSEL_CMD);
    do_op(FSC_OP_READ, 18'h00000, 16'h0000);
    check("autoselect entered", {8'h00, MFR}, {8'h00, rdata[7:0]});
    do_op(FSC_OP_RESET, 18'h00000, 16'h0000);
    check("reset pulse long", 16'h0001, {15'h0, rst_low >= 4});
    check("no restart flag", 16'h0000, {15'h0, restart_needed});
    do_op(FSC_OP_READ, 18'h00000, 16'h0000);
    check("array after reset", PAT, rdata);
    $display("t_reset_idle finished");
  endtask

  task automatic t_reset_busy;
    @(posedge clk) start_alg <= 1'b1;
    @(posedge clk) start_alg <= 1'b0;
    do_op(FSC_OP_RESET, 18'h00000, 16'h0000);
    check("ready at done", 16'h0001, {15'h0, f_rb_n});
    check("restart flag set", 16'h0001, {15'h0, restart_needed});
    do_op(FSC_OP_WRITE, 18'h00100, 16'h1234);
    check("restart flag cleared", 16'h0000, {15'h0, restart_needed});
    $display("t_reset_busy finished");
  endtask

  initial begin
    resetn    = 1'b0;
    req       = 1'b0;
    op        = FSC_OP_READ;
    req_addr  = '0;
    req_wdata = '0;
    byte_mode = 1'b0;
    top_boot  = 1'b1;
    start_alg = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_read();
    t_byte();
    t_hv_id();
    t_prot();
    t_cmd_id();
    t_reset_idle();
    t_reset_busy();
    conclude();
  end
endmodule
